// >>> logic/cplb_pkg.sv
// Constants, register map and carrier types for the logic block model.
// Assumes an APB master with 32-bit data and a 12-bit byte address.
`default_nettype none

package cplb_pkg;

  // ************************************************************
  // Array sizes
  // ************************************************************
  localparam int NUM_IN   = 36;
  localparam int NUM_MC   = 16;
  localparam int NUM_DED  = 5;
  localparam int NUM_SHR  = 32;
  localparam int NUM_CT   = 6;
  localparam int NUM_CLK  = 4;
  localparam int NUM_FB   = 2 * NUM_MC;
  localparam int SHR_BASE = NUM_MC * NUM_DED;
  localparam int CT_BASE  = SHR_BASE + NUM_SHR;
  localparam int NUM_PT   = CT_BASE + NUM_CT;
  localparam int LIT_W    = 2 * NUM_IN;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [11:0] PT_BASE       = 12'h000;
  localparam logic [11:0] MC_CFG_BASE   = 12'h800;
  localparam logic [11:0] OR_MASK_BASE  = 12'h840;
  localparam logic [11:0] GLB_CTRL_ADDR = 12'h880;
  localparam logic [11:0] STATUS_ADDR   = 12'h884;

  // ************************************************************
  // Field encodings
  // ************************************************************
  localparam logic [2:0] OE_OFF = 3'h0;
  localparam logic [2:0] OE_ON  = 3'h1;
  localparam logic [2:0] OE_CT  = 3'h2;
  localparam int CT_PRESET = 0;
  localparam int CT_RESET  = 1;
  localparam int CT_OE0    = 2;

  typedef struct packed {
    logic [2:0] oe_sel;
    logic       pr_en;
    logic [1:0] clk_sel;
    logic       fall_edge;
    logic       toggle;
  } cplb_mc_cfg_t;

  typedef struct packed {
    logic            gts_en;
    logic [5:0]      ct_sum;
    logic [2:0][3:0] clk_src_mc;
    logic [2:0]      clk_async;
  } cplb_glb_cfg_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } cplb_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cplb_apb_rsp_t;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [LIT_W-1:0] PT_RST     = '0;
  localparam cplb_mc_cfg_t     MC_CFG_RST = '0;
  localparam logic [31:0]      OR_RST     = '0;
  localparam cplb_glb_cfg_t    GLB_RST    = '0;

endpackage : cplb_pkg

`default_nettype wire

// >>> logic/cplb_logic_block.sv
// One logic block: product terms, control terms, 16 macrocells, APB config.
// Assumes clock and pin inputs synchronous to ref_clk_i; pins resolved outside.
//
// What this block does
// [R1] Each macrocell flop is configurable as D type or T type.
// [R2] Each flop captures on rising or falling edge of its clock.
// [R3] Four clock nets; net 0 is only an external synchronous clock.
// [R4] Nets 1 to 3 are external clocks or a macrocell equation.
// [R5] Six control terms, each configurable as sum or product term.
// [R6] Control terms 0 and 1 drive flop preset and reset.
// [R7] Preset and reset can be disabled per macrocell.
// [R8] Reset leaves every macrocell flop at zero.
// [R9] Control terms 2 to 5 selectable as each output enable.
// [R10] Output buffer may instead be always enabled or always disabled.
// [R11] Global tristate enabled and pin low disables every output.
// [R12] Block takes 36 interconnect inputs and holds 16 macrocells.
// [R13] Block returns 32 feedback signals from macrocells and pins.
// [R14] Each macrocell has five dedicated terms into a fixed OR.
// [R15] A pool of 32 shared terms reaches all macrocells via OR array.
// [R16] One output can combine up to 37 terms in total.
// [R17] One shared term may feed several outputs at once.
// [R18] Two feedbacks per macrocell: before buffer and from the pin.
// [R19] Input pin: buffer off, pin feeds back, macrocell still feeds back.
// [R20] T mode inverts on active edge when input high, else holds.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module cplb_logic_block (
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_i,
  input  wire cplb_pkg::cplb_apb_req_t apb_i,
  output var  cplb_pkg::cplb_apb_rsp_t apb_o,
  input  wire logic [35:0]             interconnect_array_i,
  input  wire logic                    sync_only_clock_i,
  input  wire logic                    flex_clock_a_i,
  input  wire logic                    flex_clock_b_i,
  input  wire logic                    flex_clock_c_i,
  input  wire logic                    global_tristate_pin_n_i,
  input  wire logic [15:0]             pin_in_i,
  output var  logic [15:0]             pin_out_o,
  output var  logic [15:0]             pin_oe_o,
  output var  logic [31:0]             interconnect_array_fb_o
);
  import cplb_pkg::*;

  // ************************************************************
  // Storage
  // ************************************************************
  logic [LIT_W-1:0]  pt_mem_q [NUM_PT];
  cplb_mc_cfg_t      mc_cfg_q [NUM_MC];
  logic [31:0]       or_mask_q [NUM_MC];
  cplb_glb_cfg_t     glb_q;
  logic [NUM_MC-1:0] mc_q;
  logic [NUM_CLK-1:0] clk_prev_q;
  logic [15:0]       pin_out_q;
  logic [15:0]       pin_oe_q;
  logic [NUM_FB-1:0] fb_q;
  logic              pready_q;
  logic              pslverr_q;
  logic [31:0]       prdata_q;

  // ************************************************************
  // Combinational nets
  // ************************************************************
  logic [LIT_W-1:0]   lit;
  logic [NUM_PT-1:0]  pt_val;
  logic [NUM_CT-1:0]  ct_val;
  logic [NUM_MC-1:0]  mc_sum;
  logic [NUM_CLK-1:0] clk_net;
  logic [NUM_CLK-1:0] clk_ext;
  logic [NUM_MC-1:0]  mc_edge;
  logic [NUM_MC-1:0]  mc_pr;
  logic [15:0]        oe_d;
  logic               gts_off;

  // ************************************************************
  // Product term array
  // ************************************************************
  // Literal order: true inputs low, complements high
  assign lit = {~interconnect_array_i, interconnect_array_i};

  // [R12] Terms over 36 inputs
  // An empty mask gives 0 so unused terms never fire
  always_comb begin
    for (int t = 0; t < NUM_PT; t++) begin
      pt_val[t] = (pt_mem_q[t] != PT_RST) &&
                  ((pt_mem_q[t] & lit) == pt_mem_q[t]);
    end
  end

  // [R5] Sum or product control terms
  always_comb begin
    for (int c = 0; c < NUM_CT; c++) begin
      ct_val[c] = glb_q.ct_sum[c] ? (|(pt_mem_q[CT_BASE + c] & lit))
                                  : pt_val[CT_BASE + c];
    end
  end

  // [R14] Dedicated terms, fixed OR
  // [R15] Shared pool through OR array
  // [R16] Up to 37 terms per output
  // [R17] Shared terms reused freely
  always_comb begin
    for (int m = 0; m < NUM_MC; m++) begin
      mc_sum[m] = (|pt_val[m * NUM_DED +: NUM_DED]) |
                  (|(pt_val[SHR_BASE +: NUM_SHR] & or_mask_q[m]));
    end
  end

  // ************************************************************
  // Clock networks
  // ************************************************************
  assign clk_ext = {flex_clock_c_i, flex_clock_b_i, flex_clock_a_i,
                    sync_only_clock_i};

  // [R3] Net 0 external only
  // [R4] Nets 1 to 3 selectable
  // Equation clocks use the combinational sum, so they add no ref clock lag
  always_comb begin
    clk_net[0] = clk_ext[0];
    for (int n = 1; n < NUM_CLK; n++) begin
      clk_net[n] = glb_q.clk_async[n - 1] ? mc_sum[glb_q.clk_src_mc[n - 1]]
                                          : clk_ext[n];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      // Seed from the pins so an idle-high clock gives no false edge
      clk_prev_q <= clk_ext;
    end else begin
      clk_prev_q <= clk_net;
    end
  end

  // [R2] Edge select per macrocell
  always_comb begin
    for (int m = 0; m < NUM_MC; m++) begin
      mc_edge[m] = mc_cfg_q[m].fall_edge ?
        (~clk_net[mc_cfg_q[m].clk_sel] & clk_prev_q[mc_cfg_q[m].clk_sel]) :
        (clk_net[mc_cfg_q[m].clk_sel] & ~clk_prev_q[mc_cfg_q[m].clk_sel]);
      mc_pr[m] = mc_cfg_q[m].pr_en & (ct_val[CT_PRESET] | ct_val[CT_RESET]);
    end
  end

  // ************************************************************
  // Macrocell flops
  // ************************************************************
  // [R8] Reset clears flops
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mc_q <= '0;
    end else begin
      for (int m = 0; m < NUM_MC; m++) begin
        // [R6] Reset wins over preset
        // [R7] Gated by pr_en
        if (mc_cfg_q[m].pr_en && ct_val[CT_RESET]) begin
          mc_q[m] <= 1'b0;
        end else if (mc_cfg_q[m].pr_en && ct_val[CT_PRESET]) begin
          mc_q[m] <= 1'b1;
        end else if (mc_edge[m]) begin
          // [R1] D or T type
          // [R20] Toggle when input high
          mc_q[m] <= mc_cfg_q[m].toggle ? (mc_q[m] ^ mc_sum[m]) : mc_sum[m];
        end
      end
    end
  end

  // ************************************************************
  // Output buffers and feedback
  // ************************************************************
  assign gts_off = glb_q.gts_en & ~global_tristate_pin_n_i;

  // [R9] Control term enables
  // [R10] Fixed on or off
  // [R11] Global tristate override
  always_comb begin
    for (int m = 0; m < NUM_MC; m++) begin
      case (mc_cfg_q[m].oe_sel)
        OE_OFF:  oe_d[m] = 1'b0;
        OE_ON:   oe_d[m] = 1'b1;
        3'h2:    oe_d[m] = ct_val[CT_OE0];
        3'h3:    oe_d[m] = ct_val[CT_OE0 + 1];
        3'h4:    oe_d[m] = ct_val[CT_OE0 + 2];
        3'h5:    oe_d[m] = ct_val[CT_OE0 + 3];
        default: oe_d[m] = 1'b0;
      endcase
      oe_d[m] = oe_d[m] & ~gts_off;
    end
  end

  // [R13] 32 feedback signals
  // [R18] Macrocell and pin paths
  // [R19] Pin path reads the wire
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_out_q <= '0;
      pin_oe_q  <= '0;
      fb_q      <= '0;
    end else begin
      pin_out_q <= mc_q;
      pin_oe_q  <= oe_d;
      fb_q      <= {pin_in_i, mc_q};
    end
  end

  assign pin_out_o               = pin_out_q;
  assign pin_oe_o                = pin_oe_q;
  assign interconnect_array_fb_o = fb_q;

  // ************************************************************
  // APB decode
  // ************************************************************
  logic [6:0]  pt_idx;
  logic [1:0]  pt_word;
  logic [3:0]  mc_idx;
  logic        sel_pt;
  logic        sel_mc;
  logic        sel_or;
  logic        sel_glb;
  logic        sel_st;
  logic        acc_first;
  logic        wr_en;
  logic [31:0] rd_data;
  logic        rd_err;

  assign pt_idx    = apb_i.paddr[10:4];
  assign pt_word   = apb_i.paddr[3:2];
  assign mc_idx    = apb_i.paddr[5:2];
  assign sel_pt    = (apb_i.paddr[11] == PT_BASE[11]) && (pt_idx < 7'(NUM_PT));
  assign sel_mc    = apb_i.paddr[11:6] == MC_CFG_BASE[11:6];
  assign sel_or    = apb_i.paddr[11:6] == OR_MASK_BASE[11:6];
  assign sel_glb   = apb_i.paddr[11:2] == GLB_CTRL_ADDR[11:2];
  assign sel_st    = apb_i.paddr[11:2] == STATUS_ADDR[11:2];
  assign acc_first = apb_i.psel & apb_i.penable & ~pready_q;
  assign wr_en     = apb_i.psel & apb_i.penable & apb_i.pwrite & pready_q;

  always_comb begin
    rd_data = '0;
    rd_err  = 1'b0;
    if (sel_pt) begin
      case (pt_word)
        2'h0:    rd_data = pt_mem_q[pt_idx][31:0];
        2'h1:    rd_data = pt_mem_q[pt_idx][67:36];
        2'h2:    rd_data = {24'h0, pt_mem_q[pt_idx][71:68], pt_mem_q[pt_idx][35:32]};
        default: rd_data = '0;
      endcase
    end else if (sel_mc) begin
      rd_data = {24'h0, mc_cfg_q[mc_idx]};
    end else if (sel_or) begin
      rd_data = or_mask_q[mc_idx];
    end else if (sel_glb) begin
      rd_data = {10'h0, glb_q};
    end else if (sel_st) begin
      rd_data = {pin_in_i, mc_q};
    end else begin
      rd_err = 1'b1;
    end
  end

  // ************************************************************
  // APB response
  // ************************************************************
  // One wait state keeps prdata and pready on flops
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q <= acc_first;
      if (acc_first) begin
        pslverr_q <= rd_err;
        prdata_q  <= apb_i.pwrite ? 32'h0 : rd_data;
      end
    end
  end

  assign apb_o = '{prdata: prdata_q, pready: pready_q, pslverr: pslverr_q};

  // ************************************************************
  // Configuration registers
  // ************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int t = 0; t < NUM_PT; t++) begin
        pt_mem_q[t] <= PT_RST;
      end
    end else if (wr_en && sel_pt) begin
      case (pt_word)
        2'h0: pt_mem_q[pt_idx][31:0] <= apb_i.pwdata;
        2'h1: pt_mem_q[pt_idx][67:36] <= apb_i.pwdata;
        2'h2: begin
          pt_mem_q[pt_idx][71:68] <= apb_i.pwdata[7:4];
          pt_mem_q[pt_idx][35:32] <= apb_i.pwdata[3:0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int m = 0; m < NUM_MC; m++) begin
        mc_cfg_q[m] <= MC_CFG_RST;
      end
    end else if (wr_en && sel_mc) begin
      mc_cfg_q[mc_idx] <= apb_i.pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      for (int m = 0; m < NUM_MC; m++) begin
        or_mask_q[m] <= OR_RST;
      end
    end else if (wr_en && sel_or) begin
      or_mask_q[mc_idx] <= apb_i.pwdata;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      glb_q <= GLB_RST;
    end else if (wr_en && sel_glb) begin
      glb_q <= apb_i.pwdata[21:0];
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // [R8] Power up zero
  a_power_up_zero: assert property (disable iff (1'b0) rst_i |=> (mc_q == '0)) // [R8]
    else $error("flops not zero after reset");

  // [R18] Both feedback paths
  a_feedback_pair: assert property (##1 (fb_q == {$past(pin_in_i), $past(mc_q)})) // [R18]
    else $error("feedback mismatch");

  // [R3] Net 0 external
  a_sync_only_clock_external: assert property ( // [R3]
    $changed(sync_only_clock_i) == (clk_net[0] ^ clk_prev_q[0]))
    else $error("clock net 0 not external");

  a_apb_wait_one: assert property (acc_first |=> pready_q ##1 !pready_q)
    else $error("apb answer timing wrong");

  for (genvar g = 0; g < NUM_MC; g++) begin : g_chk
    // [R1] D capture
    a_dff_capture: assert property ( // [R1]
      (!mc_cfg_q[g].toggle && mc_edge[g] && !mc_pr[g]) |=> (mc_q[g] == $past(mc_sum[g])))
      else $error("d capture wrong");
    // [R20] T toggle
    a_tff_toggle: assert property ( // [R20]
      (mc_cfg_q[g].toggle && mc_edge[g] && !mc_pr[g])
        |=> (mc_q[g] == ($past(mc_q[g]) ^ $past(mc_sum[g]))))
      else $error("t toggle wrong");
    // [R2] Hold without edge
    a_hold_no_edge: assert property ( // [R2]
      (!mc_edge[g] && !mc_pr[g]) |=> $stable(mc_q[g]))
      else $error("flop moved without edge");
    // [R6] Reset term clears
    a_reset_term: assert property ( // [R6]
      (mc_cfg_q[g].pr_en && ct_val[CT_RESET]) |=> !mc_q[g])
      else $error("reset term ignored");
    // [R7] Disabled preset reset
    a_pr_disable: assert property ( // [R7]
      (!mc_cfg_q[g].pr_en && !mc_edge[g]) |=> $stable(mc_q[g]))
      else $error("disabled preset reset acted");
    // [R11] Global tristate
    a_oe_global: assert property ( // [R11]
      gts_off |=> !pin_oe_o[g])
      else $error("output on under global tristate");
    // [R10] Always enabled
    a_oe_fixed: assert property ( // [R10]
      (mc_cfg_q[g].oe_sel == OE_ON && !gts_off) |=> pin_oe_o[g])
      else $error("fixed enable not driving");
  end

endmodule // cplb_logic_block

`default_nettype wire

// >>> sim/cplb_logic_block_test.sv
// Self-checking bench for the logic block: APB config, flops, enables.
// Assumes one APB wait state and outputs registered one cycle late.
`timescale 1ns/1ps
`default_nettype none

module cplb_logic_block_test;
  import cplb_pkg::*;

  logic          ref_clk_i;
  logic          rst_i;
  cplb_apb_req_t req;
  cplb_apb_rsp_t rsp;
  logic [35:0]   ic;
  logic [3:0]    clks;
  logic          gts_n;
  logic [15:0]   pin;
  logic [15:0]   pin_out;
  logic [15:0]   pin_oe;
  logic [31:0]   fb;
  logic [33:0]   notes[$];
  logic [7:0]    cfgs[8] = '{8'h20, 8'h21, 8'h22, 8'h20, 8'h20, 8'h50, 8'h00, 8'h04};
  logic [35:0]   icv[3] = '{36'h0B, 36'h04, 36'h02};
  logic [15:0]   flv[3] = '{16'h001B, 16'h0006, 16'h0000};
  int            errors;
  int            total_checks;
  int            seed;

  cplb_logic_block dut (
    .ref_clk_i               (ref_clk_i),
    .rst_i                   (rst_i),
    .apb_i                   (req),
    .apb_o                   (rsp),
    .interconnect_array_i    (ic),
    .sync_only_clock_i       (clks[0]),
    .flex_clock_a_i          (clks[1]),
    .flex_clock_b_i          (clks[2]),
    .flex_clock_c_i          (clks[3]),
    .global_tristate_pin_n_i (gts_n),
    .pin_in_i                (pin),
    .pin_out_o               (pin_out),
    .pin_oe_o                (pin_oe),
    .interconnect_array_fb_o (fb)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // Request held until pready is seen; bounded so a dead slave still ends
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] exp, input logic err);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= a;
    req.pwdata  <= d;
    notes.push_back({w, err, exp});
    @(posedge ref_clk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0, exp, err);
  endtask

  // Status read with fresh random pin levels in the upper half
  task automatic st(input logic [15:0] f);
    logic [15:0] p;
    p = 16'($random(seed));
    pin <= p;
    rd(STATUS_ADDR, {p, f}, 1'b0);
  endtask

  task automatic pulse();
    clks[0] <= 1'b1;
    cyc(4);
    clks[0] <= 1'b0;
    cyc(4);
  endtask

  // ************************************************************
  // Response monitor
  // ************************************************************
  always @(posedge ref_clk_i) begin
    logic [33:0] nt;
    if (req.psel && req.penable && rsp.pready === 1'b1) begin
      nt = notes.pop_front();
      check({31'h0, rsp.pslverr}, {31'h0, nt[32]});
      if (!nt[33]) check(rsp.prdata, nt[31:0]);
    end
  end

  initial begin
    cyc(20000);
    errors++;
    test_done();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    seed = 1;
    errors = 0;
    total_checks = 0;
    rst_i = 1'b1;
    req = '0;
    ic = '0;
    clks = '0;
    gts_n = 1'b1;
    pin = '0;
    cyc(2);
    rst_i <= 1'b0;
    st(16'h0000);
    rd(MC_CFG_BASE, 32'h0, 1'b0);
    rd(GLB_CTRL_ADDR, 32'h0, 1'b0);
    check(32'(pin_oe), 32'h0);
    rd(12'h888, 32'h0, 1'b1);
    wr(STATUS_ADDR, 32'hFFFFFFFF);
    // Terms: 0,5,10 dedicated; 80 shared; 112..114 control; 35 for mc7
    wr(12'h000, 32'h01);
    wr(12'h050, 32'h02);
    wr(12'h0A0, 32'h04);
    wr(12'h500, 32'h08);
    wr(12'h700, 32'h10);
    wr(12'h710, 32'h20);
    wr(12'h720, 32'hC0);
    wr(12'h230, 32'h80);
    for (int m = 0; m < 8; m++) begin
      wr(MC_CFG_BASE + 12'(4 * m), {24'h0, cfgs[m]});
    end
    wr(OR_MASK_BASE + 12'h00C, 32'h1);
    wr(OR_MASK_BASE + 12'h010, 32'h1);
    rd(MC_CFG_BASE + 12'h004, 32'h21, 1'b0);
    // D, T and falling-edge flops plus one shared term on two cells
    for (int i = 0; i < 3; i++) begin
      ic <= icv[i];
      cyc(2);
      pulse();
      st(flv[i]);
      check(32'(pin_out), 32'(flv[i]));
    end
    check(32'(pin_oe), 32'h001F);
    // Preset on mc5 only; mc6 has preset/reset disabled
    ic <= 36'hD0;
    cyc(4);
    st(16'h0020);
    check(32'(pin_oe), 32'h003F);
    ic <= 36'h20;
    cyc(4);
    st(16'h0000);
    check(32'(pin_oe), 32'h001F);
    // Net 1 from mc0 equation, CT2 as sum term, global tristate on
    wr(GLB_CTRL_ADDR, 32'h0022_0001);
    rd(GLB_CTRL_ADDR, 32'h0022_0001, 1'b0);
    gts_n <= 1'b0;
    cyc(4);
    check(32'(pin_oe), 32'h0);
    gts_n <= 1'b1;
    ic <= 36'h80;
    cyc(4);
    ic <= 36'h81;
    cyc(4);
    st(16'h0080);
    check(32'(pin_oe), 32'h003F);
    check(fb, {pin, 16'h0080});
    // Complement and upper literals, net 2 clock, CT3 enable on mc8
    wr(12'h284, 32'h1);
    wr(12'h288, 32'h1);
    rd(12'h288, 32'h1, 1'b0);
    rd(12'h28C, 32'h0, 1'b0);
    wr(12'h734, 32'h2);
    wr(MC_CFG_BASE + 12'h020, 32'h68);
    ic <= 36'h1_0000_0000;
    cyc(2);
    clks[2] <= 1'b1;
    cyc(4);
    st(16'h0180);
    check(32'(pin_oe), 32'h011F);
    clks[2] <= 1'b0;
    ic <= 36'h0;
    cyc(4);
    clks[2] <= 1'b1;
    cyc(4);
    st(16'h0080);
    test_done();
  end

endmodule // cplb_logic_block_test

`default_nettype wire
